// ---- design/port_crossbar_defines.vh ----
// Register offsets, field positions and reset values of the port crossbar
// and port-match block. Included by the crossbar design file; the mismatch detector does not use it.
`ifndef PORT_CROSSBAR_DEFINES_VH
`define PORT_CROSSBAR_DEFINES_VH

// Printed offsets are not all multiples of four: they are register indices.
`define IDX_GLOBAL_CONTROL   8'hc7
`define IDX_ROUTE_SECOND     8'he2
`define IDX_P0_SELECT        8'hf2
`define IDX_P0_EXPECTED      8'hf1
`define IDX_P1_SELECT        8'hf4
`define IDX_P1_EXPECTED      8'hf3
`define IDX_P2_SELECT        8'hb2
`define IDX_P2_EXPECTED      8'hb1
`define IDX_P3_SELECT        8'haf
`define IDX_P3_EXPECTED      8'hae
`define IDX_MATCH_STATUS     8'hd0
`define IDX_PAGE_SELECT      8'hd1

`define PAGE_CONFIG          8'h0f
`define PAGE_MATCH           8'h00

`define RST_GLOBAL_CONTROL   8'h00
`define RST_ROUTE_SECOND     8'h00
`define RST_SELECT           8'h00
`define RST_EXPECTED         8'hff
`define RST_PAGE             8'h00

// Global control fields.
`define GC_PULLUP_DIS        7
`define GC_XBAR_EN           6
`define GC_LIN_EN            0
`define GC_WRITE_MASK        8'hc1

// Second route register fields.
`define RS_TIMER1_EN         7
`define RS_TIMER0_EN         6
`define RS_ECI_EN            5
`define RS_CAP_HI            4
`define RS_CAP_LO            2
`define RS_SYSTEM_CLOCK_EN         1
`define RS_WRITE_MASK        8'hfe

`define CAP_RESERVED         3'h7
`endif

// ---- design/port_mismatch_detect.v ----
// Per-port masked comparison of synchronised pin levels.
// Assumes pins come from outside the clock domain; levels are caught by
// two flip-flops here before any comparison reads them.
`timescale 1ns/10ps

module port_mismatch_detect (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [7:0]  pin_in,
  input  wire [7:0]  expected,
  input  wire [7:0]  compare_select,
  output reg         mismatch_r
);

  reg [7:0] sync1_r;
  reg [7:0] sync2_r;

  // ----------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------------
  // Comparison
  // ----------------------------------------------------------------------
  // A deselected pin is masked on both sides and so can never differ.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mismatch_r <= 1'b0;
    end else begin
      mismatch_r <= ((sync2_r & compare_select) !=
                     (expected & compare_select));
    end
  end

endmodule

// ---- design/port_crossbar.v ----
// Port crossbar routing enables and port-match event logic, APB slave.
// Assumes a 32-bit APB master on ref_clk; pins arrive asynchronously.
//
// Overview of operation
// - Route-second bit 7 routes timer 1 external input to a pin.
// - Route-second bit 6 routes timer 0 external input to a pin.
// - Route-second bit 5 routes counter array external clock input.
// - Field 4:2 routes capture outputs 0..value-1 cumulatively; 111 reserved.
// - Route-second bit 1 drives the system clock out on a pin.
// - Global bit 7 clear enables weak pullups except analog pins.
// - Global bit 0 routes LIN transmit and receive to pins.
// - Each port 0-3 has a software-written expected value.
// - Mismatch when masked pins differ from masked expected value.
// - Mismatch observes pins regardless of crossbar routing.
// - Mismatch event serves as interrupt source and wake-up source.
// - Compare-select bit 0 excludes its pin, 1 includes it.
// - Route-second register at 0xE2 page 0x0F, resets to zero.
// - Global control at 0xC7 page 0x0F, resets to zero.
// - Port 0 compare-select at 0xF2 page 0x00, resets to zero.
// - Global bit 6 enables crossbar; else pins stay plain inputs.
// - Crossbar disabled keeps every port output driver disabled.
// - Expected value bit sets compared level; resets to all ones.
`timescale 1ns/10ps
`include "port_crossbar_defines.vh"

module port_crossbar (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  port0_pins,
  input  wire [7:0]  port1_pins,
  input  wire [7:0]  port2_pins,
  input  wire [7:0]  port3_pins,
  input  wire [3:0]  analog_ports,
  output reg         timer1_input_route_en,
  output reg         timer0_input_route_en,
  output reg         counter_ext_clock_route_en,
  output reg  [5:0]  capture_out_route_en,
  output reg         system_clock_pin_out_en,
  output reg         lin_route_en,
  output reg         crossbar_global_en,
  output reg         port_output_drivers_en,
  output reg  [3:0]  port_pullup_en,
  output reg         match_irq,
  output reg         match_wakeup
);

  reg  [7:0]  crossbar_global_control_r;
  reg  [7:0]  crossbar_route_enables_second_r;
  reg  [7:0]  page_r;
  reg  [7:0]  sel_r [0:3];
  reg  [7:0]  exp_r [0:3];
  wire [3:0]  port_mismatch;
  wire [31:0] port_bus;
  reg  [7:0]  rd_byte;
  reg         hit;
  reg  [5:0]  cap_nxt;

  assign port_bus = {port3_pins, port2_pins, port1_pins, port0_pins};

  // Register index lookup: returns {valid, kind, port} for match registers.
  // kind 0 = compare select, 1 = expected value.
  function [3:0] match_decode;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_P0_SELECT:   match_decode = 4'b1000;
        `IDX_P1_SELECT:   match_decode = 4'b1001;
        `IDX_P2_SELECT:   match_decode = 4'b1010;
        `IDX_P3_SELECT:   match_decode = 4'b1011;
        `IDX_P0_EXPECTED: match_decode = 4'b1100;
        `IDX_P1_EXPECTED: match_decode = 4'b1101;
        `IDX_P2_EXPECTED: match_decode = 4'b1110;
        `IDX_P3_EXPECTED: match_decode = 4'b1111;
        default:          match_decode = 4'b0000;
      endcase
    end
  endfunction

  wire [7:0] idx = paddr[9:2];
  wire [3:0] mdec = match_decode(idx);
  wire       acc = psel & penable & pready;
  wire       wr_en = acc & pwrite;
  wire       is_cfg_page = (page_r == `PAGE_CONFIG);
  wire       is_match_page = (page_r == `PAGE_MATCH);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // The page register is reachable from every page so software can leave
  // any page; every other register is only visible in its own page.
  always @* begin
    rd_byte = 8'h00;
    hit     = 1'b0;
    if (paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00) begin
      if (idx == `IDX_PAGE_SELECT) begin
        hit     = 1'b1;
        rd_byte = page_r;
      end else if (is_cfg_page && idx == `IDX_GLOBAL_CONTROL) begin
        hit     = 1'b1;
        rd_byte = crossbar_global_control_r;
      end else if (is_cfg_page && idx == `IDX_ROUTE_SECOND) begin
        hit     = 1'b1;
        rd_byte = crossbar_route_enables_second_r;
      end else if (is_match_page && idx == `IDX_MATCH_STATUS) begin
        hit     = 1'b1;
        rd_byte = {4'h0, port_mismatch};
      end else if (is_match_page && mdec[3]) begin
        hit     = 1'b1;
        rd_byte = mdec[2] ? exp_r[mdec[1:0]] : sel_r[mdec[1:0]];
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB slave handshake
  // ----------------------------------------------------------------------
  // One wait state: pready rises in the second access cycle, so each
  // transfer takes setup plus two access cycles.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~hit;
      prdata  <= (hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Reserved bits are held at zero by write masks, whatever software does.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      page_r                          <= `RST_PAGE;
      crossbar_global_control_r       <= `RST_GLOBAL_CONTROL;
      crossbar_route_enables_second_r <= `RST_ROUTE_SECOND;
    end else if (wr_en && hit) begin
      if (idx == `IDX_PAGE_SELECT)
        page_r <= pwdata[7:0];
      else if (idx == `IDX_GLOBAL_CONTROL)
        crossbar_global_control_r <= pwdata[7:0] & `GC_WRITE_MASK;
      else if (idx == `IDX_ROUTE_SECOND)
        crossbar_route_enables_second_r <=
          pwdata[7:0] & `RS_WRITE_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_port
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          sel_r[g] <= `RST_SELECT;
          exp_r[g] <= `RST_EXPECTED;
        end else if (wr_en && hit && mdec[3] && mdec[1:0] == g) begin
          if (mdec[2])
            exp_r[g] <= pwdata[7:0];
          else
            sel_r[g] <= pwdata[7:0];
        end
      end

      // Pins are taken straight from the pads, not from crossbar routing.
      port_mismatch_detect u_detect (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .pin_in         (port_bus[8*g+7:8*g]),
        .expected       (exp_r[g]),
        .compare_select (sel_r[g]),
        .mismatch_r     (port_mismatch[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Routing outputs
  // ----------------------------------------------------------------------
  wire       xbar_on = crossbar_global_control_r[`GC_XBAR_EN];
  wire [2:0] cap_field =
    crossbar_route_enables_second_r[`RS_CAP_HI:`RS_CAP_LO];

  always @* begin
    if (cap_field == `CAP_RESERVED)
      cap_nxt = 6'h00;
    else
      cap_nxt = 6'h3f >> (3'h6 - cap_field);
  end

  // Nothing is routed while the crossbar is off; pins stay plain inputs.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer1_input_route_en      <= 1'b0;
      timer0_input_route_en      <= 1'b0;
      counter_ext_clock_route_en <= 1'b0;
      capture_out_route_en       <= 6'h00;
      system_clock_pin_out_en          <= 1'b0;
      lin_route_en               <= 1'b0;
      crossbar_global_en         <= 1'b0;
      port_output_drivers_en     <= 1'b0;
      port_pullup_en             <= 4'h0;
      match_irq                  <= 1'b0;
      match_wakeup               <= 1'b0;
    end else begin
      timer1_input_route_en      <= xbar_on &
        crossbar_route_enables_second_r[`RS_TIMER1_EN];
      timer0_input_route_en      <= xbar_on &
        crossbar_route_enables_second_r[`RS_TIMER0_EN];
      counter_ext_clock_route_en <= xbar_on &
        crossbar_route_enables_second_r[`RS_ECI_EN];
      capture_out_route_en       <= xbar_on ? cap_nxt : 6'h00;
      system_clock_pin_out_en          <= xbar_on &
        crossbar_route_enables_second_r[`RS_SYSTEM_CLOCK_EN];
      lin_route_en               <= xbar_on &
        crossbar_global_control_r[`GC_LIN_EN];
      crossbar_global_en         <= xbar_on;
      port_output_drivers_en     <= xbar_on;
      port_pullup_en             <= ~analog_ports &
        {4{~crossbar_global_control_r[`GC_PULLUP_DIS]}};
      match_irq                  <= |port_mismatch;
      match_wakeup               <= |port_mismatch;
    end
  end

endmodule

// ---- verification/port_crossbar_assertions.sv ----
// Concurrent checks on the ports of the crossbar and port-match block.
// Assumes one clock domain, ref_clk, with rst asynchronous and active high.
`timescale 1ns/10ps

module port_crossbar_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer1_input_route_en,
  input wire logic        timer0_input_route_en,
  input wire logic        counter_ext_clock_route_en,
  input wire logic [5:0]  capture_out_route_en,
  input wire logic        system_clock_pin_out_en,
  input wire logic        lin_route_en,
  input wire logic        crossbar_global_en,
  input wire logic        port_output_drivers_en,
  input wire logic        match_irq,
  input wire logic        match_wakeup
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
  a_ready_wait:
    assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_ready_cause:
    assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_reads_zero:
    assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_idle_quiet:
    assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer cycle");
  a_drivers_follow_xbar:
    assert property (port_output_drivers_en == crossbar_global_en)
    else $error("drivers enabled without crossbar");
  a_routes_gated:
    assert property (!crossbar_global_en |-> {timer1_input_route_en,
      timer0_input_route_en, counter_ext_clock_route_en, system_clock_pin_out_en,
      lin_route_en, capture_out_route_en} == 11'h0)
    else $error("route active with crossbar disabled");
  a_capture_cumulative:
    assert property (((capture_out_route_en + 6'h1) & capture_out_route_en)
      == 6'h0) else $error("capture routes not contiguous from zero");
  a_wake_with_irq:
    assert property (match_wakeup == match_irq)
    else $error("wake-up differs from interrupt");
endmodule

bind port_crossbar port_crossbar_checker u_port_crossbar_checker (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer1_input_route_en(timer1_input_route_en),
  .timer0_input_route_en(timer0_input_route_en),
  .counter_ext_clock_route_en(counter_ext_clock_route_en),
  .capture_out_route_en(capture_out_route_en),
  .system_clock_pin_out_en(system_clock_pin_out_en), .lin_route_en(lin_route_en),
  .crossbar_global_en(crossbar_global_en),
  .port_output_drivers_en(port_output_drivers_en),
  .match_irq(match_irq), .match_wakeup(match_wakeup));

// ---- verification/port_pad_model.sv ----
// Pads of ports 0-3 as seen from outside the device.
// Assumes the bench gives drive level and drive enable per pin.
`timescale 1ns/10ps

module port_pad_model (
  input  wire logic        ref_clk,
  input  wire logic [31:0] pad_drive,
  input  wire logic [31:0] pad_oe,
  input  wire logic [3:0]  port_pullup_en,
  output logic      [31:0] pads
);
  logic [31:0] float_r = 32'h5a5a5a5a;

  // An undriven pin without pullup wanders, so nothing may rely on it.
  always @(posedge ref_clk) float_r <= ~float_r;
  always_comb
    for (int i = 0; i < 32; i++)
      pads[i] = pad_oe[i] ? pad_drive[i] :
                port_pullup_en[i/8] ? 1'b1 : float_r[i];
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench of the crossbar block over APB, random and corners.
// Assumes the defines header of the design on the include path.
`timescale 1ns/10ps
`include "port_crossbar_defines.vh"

module tb_top;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, drv, pads, seed, rv;
  logic [3:0]  analog, pull, mm;
  logic        t1, t0, counter_ext_clock_in, sck, lin, xen, den, irq, wake, e;
  logic [5:0]  cap;
  logic [7:0]  rt, gc, d, sel [4], ex [4];
  logic [7:0]  sidx [4] = '{`IDX_P0_SELECT, `IDX_P1_SELECT,
                            `IDX_P2_SELECT, `IDX_P3_SELECT};
  logic [7:0]  eidx [4] = '{`IDX_P0_EXPECTED, `IDX_P1_EXPECTED,
                            `IDX_P2_EXPECTED, `IDX_P3_EXPECTED};
  int          err_total = 0, n_tests = 0;

  port_crossbar u_port_crossbar (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port0_pins(pads[7:0]), .port1_pins(pads[15:8]),
    .port2_pins(pads[23:16]), .port3_pins(pads[31:24]),
    .analog_ports(analog), .timer1_input_route_en(t1),
    .timer0_input_route_en(t0), .counter_ext_clock_route_en(counter_ext_clock_in),
    .capture_out_route_en(cap), .system_clock_pin_out_en(sck),
    .lin_route_en(lin), .crossbar_global_en(xen),
    .port_output_drivers_en(den), .port_pullup_en(pull),
    .match_irq(irq), .match_wakeup(wake));
  port_pad_model u_port_pad_model (.ref_clk(ref_clk), .pad_drive(drv),
    .pad_oe(32'hffffffff), .port_pullup_en(pull), .pads(pads));

  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [5:0] cap_exp(input logic [2:0] f);
    return (f == 3'h7) ? 6'h0 : 6'h3f >> (6 - f);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  // Request is held until pready is sampled high, then released.
  task automatic apb(input logic wr, input logic [7:0] idx, wd,
                     output logic [7:0] rd, output logic er);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1; penable <= 0; pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00}; pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end else begin
      rd = prdata[7:0];
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask

  task automatic wr(input logic [7:0] idx, wd);
    apb(1'b1, idx, wd, d, e);
  endtask

  task automatic rd(input logic [7:0] idx, exp, input string nm);
    apb(1'b0, idx, 8'h0, d, e);
    check(nm, {e, d}, {1'b0, exp});
  endtask

  initial begin
    seed = 32'h2e708664;
    {psel, penable, pwrite, paddr, pwdata, drv, analog} = '0;
    rst = 1;
    repeat (6) @(posedge ref_clk);
    rst <= 0;
    wr(`IDX_PAGE_SELECT, `PAGE_CONFIG);
    rd(`IDX_GLOBAL_CONTROL, 8'h00, "global reset");
    rd(`IDX_ROUTE_SECOND, 8'h00, "route reset");
    apb(1'b0, 8'h00, 8'h0, d, e);
    check("unmapped read", {e, d}, 9'h100);
    for (int i = 0; i < 8; i++) begin
      // Draws go to a bench variable: pwdata may still be sampled here.
      rv = rnd();
      rt = {rv[7:5], 3'(i), rv[1], 1'b0};
      gc = {rv[15], 6'h0, rv[8]};
      analog <= rv[19:16];
      wr(`IDX_ROUTE_SECOND, rt);
      wr(`IDX_GLOBAL_CONTROL, gc);
      repeat (2) @(posedge ref_clk);
      check("routes off", {t1, t0, counter_ext_clock_in, sck, lin, cap, den, xen},
        0);
      gc[6] = 1'b1;
      wr(`IDX_GLOBAL_CONTROL, gc);
      repeat (2) @(posedge ref_clk);
      check("routes", {t1, t0, counter_ext_clock_in, sck, lin, cap, den, xen}, {rt[7:5],
        rt[1], gc[0], cap_exp(rt[4:2]), 2'b11});
      check("pullups", pull, ~analog & {4{~gc[7]}});
      rd(`IDX_ROUTE_SECOND, rt, "route readback");
      rd(`IDX_GLOBAL_CONTROL, gc, "global readback");
    end
    wr(`IDX_PAGE_SELECT, `PAGE_MATCH);
    rd(`IDX_P0_SELECT, 8'h00, "select reset");
    rd(`IDX_P0_EXPECTED, 8'hff, "expected reset");
    for (int k = 0; k < 12; k++) begin
      for (int p = 0; p < 4; p++) begin
        rv = rnd();
        sel[p] = (k == 0) ? 8'h00 : rv[7:0];
        ex[p] = rv[15:8];
        drv[p*8 +: 8] <= (k % 3 == 1) ? rv[15:8] : rv[23:16];
        wr(sidx[p], sel[p]);
        wr(eidx[p], ex[p]);
      end
      repeat (6) @(posedge ref_clk);
      for (int p = 0; p < 4; p++)
        mm[p] = |((drv[p*8 +: 8] ^ ex[p]) & sel[p]);
      check("irq", irq, |mm);
      check("wakeup", wake, |mm);
      rd(`IDX_MATCH_STATUS, {4'h0, mm}, "status");
    end
    tally_and_finish();
  end
endmodule
